// ===== src/override_bank.sv
// Purpose: APB debug override bank steering the motor control core
// Assumes: Core signals share clk; APB master keeps the protocol
// Notes: Override registers are write-only and read as zero
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "override_defines.svh"

module override_bank (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] preset_lock_position,
    input wire logic [15:0] override_lock_position,
    input wire override_pkg::scale_t full_scale_current,
    input wire logic velocity_regulator_off,
    input wire override_pkg::sector_t last_sector,
    input wire logic param_measure_done,
    output logic [15:0] lock_position_q,
    output override_pkg::target_t torque_current_target_q,
    output logic torque_override_active_q,
    output override_pkg::target_t direct_modulation_target_q,
    output override_pkg::target_t quadrature_modulation_target_q,
    output logic torque_regulator_en_q,
    output logic velocity_regulator_en_q,
    output override_pkg::sector_t recirc_sector_q,
    output logic recirc_enable_q,
    output logic [3:0] measure_select_q,
    output logic param_measure_start_q,
    output logic param_measure_commit_q,
    output logic measure_busy_q
);

    logic [31:0] ovr_a_q, ovr_a_d, ovr_b_q, ovr_b_d;
    logic [31:0] prdata_q, prdata_d;
    logic wr_a, wr_b, rd_setup, mapped;
    logic iq_bad, vd_bad, vq_bad;
    logic [15:0] lock_d;
    logic trq_ovr_d, trq_en_d, vel_en_d, rec_en_d, busy_d;
    logic start_d, commit_d;
    override_pkg::sector_t sect_d;

    // Address decode; zero wait states so pready is high in every access
    always_comb begin
        mapped = (paddr == `ADDR_OVR_A) || (paddr == `ADDR_OVR_B) ||
                 (paddr == `ADDR_STATUS);
        wr_a = psel && penable && pwrite && (paddr == `ADDR_OVR_A);
        wr_b = psel && penable && pwrite && (paddr == `ADDR_OVR_B);
        rd_setup = psel && !penable && !pwrite;
    end
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    // Register storage; written words land at the access edge
    always_comb begin
        ovr_a_d = wr_a ? pwdata : ovr_a_q;
        ovr_b_d = wr_b ? pwdata : ovr_b_q;
        prdata_d = prdata_q;
        if (rd_setup) begin
            // Write-only words read zero; only status shows state
            prdata_d = (paddr == `ADDR_STATUS) ?
                {25'h0000000, iq_bad, vd_bad, vq_bad, trq_en_d,
                 vel_en_d, trq_ovr_d, measure_busy_q} : `RESET_WORD;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ovr_a_q <= `RESET_WORD;
            ovr_b_q <= `RESET_WORD;
            prdata_q <= `RESET_WORD;
        end else begin
            ovr_a_q <= ovr_a_d;
            ovr_b_q <= ovr_b_d;
            prdata_q <= prdata_d;
        end
    end

    // Override decode toward the control core
    always_comb begin
        lock_d = ovr_a_q[`A_SRC_SEL] ? override_lock_position :
                 preset_lock_position;
        trq_en_d = !ovr_b_q[`B_CUR_OFF];
        vel_en_d = trq_en_d && !velocity_regulator_off;
        trq_ovr_d = velocity_regulator_off && trq_en_d;
        rec_en_d = !ovr_b_q[`B_RECIRC_N];
        sect_d = ovr_b_q[`B_SECT_HI:`B_SECT_LO];
        if (sect_d == `SECT_LAST_A || sect_d == `SECT_LAST_B) begin
            sect_d = last_sector;
        end
        // One-cycle launch pulses from a write with the bit set
        start_d = wr_b && pwdata[`B_START];
        commit_d = wr_b && pwdata[`B_COMMIT];
        // A new start wins over a done in the same cycle
        busy_d = start_d || (measure_busy_q && !param_measure_done);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lock_position_q <= 16'h0000;
            torque_regulator_en_q <= 1'b1;
            velocity_regulator_en_q <= 1'b1;
            torque_override_active_q <= 1'b0;
            recirc_enable_q <= 1'b1;
            recirc_sector_q <= 3'h0;
            measure_select_q <= 4'h0;
            param_measure_start_q <= 1'b0;
            param_measure_commit_q <= 1'b0;
            measure_busy_q <= 1'b0;
        end else begin
            lock_position_q <= lock_d;
            torque_regulator_en_q <= trq_en_d;
            velocity_regulator_en_q <= vel_en_d;
            torque_override_active_q <= trq_ovr_d;
            recirc_enable_q <= rec_en_d;
            recirc_sector_q <= sect_d;
            measure_select_q <= ovr_b_q[`B_SEL_HI:`B_SEL_LO];
            param_measure_start_q <= start_d;
            param_measure_commit_q <= commit_d;
            measure_busy_q <= busy_d;
        end
    end

    // Torque target in full-scale current units
    override_scaler u_iq (
        .clk(clk),
        .rst(rst),
        .code(ovr_a_q[`A_IQ_HI:`A_IQ_LO]),
        .full_scale(full_scale_current),
        .target_q(torque_current_target_q),
        .invalid_q(iq_bad)
    );

    // Voltage targets as Q15 fractions of full modulation
    override_scaler u_vd (
        .clk(clk),
        .rst(rst),
        .code(ovr_b_q[`B_VD_HI:`B_VD_LO]),
        .full_scale(`MOD_FULL_SCALE),
        .target_q(direct_modulation_target_q),
        .invalid_q(vd_bad)
    );

    override_scaler u_vq (
        .clk(clk),
        .rst(rst),
        .code(ovr_b_q[`B_VQ_HI:`B_VQ_LO]),
        .full_scale(`MOD_FULL_SCALE),
        .target_q(quadrature_modulation_target_q),
        .invalid_q(vq_bad)
    );

    // Checks on the bank's own outputs
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wr_b;
        psel && penable && pwrite && paddr == `ADDR_OVR_B;
    endsequence

    property p_src_sel;
        ovr_a_q[`A_SRC_SEL] && $stable(override_lock_position)
            |=> lock_position_q == $past(override_lock_position);
    endproperty
    a_src_sel: assert property (p_src_sel)
        else $error("lock source wrong");

    property p_trq_ovr;
        velocity_regulator_off && !ovr_b_q[`B_CUR_OFF]
            |=> torque_override_active_q;
    endproperty
    a_trq_ovr: assert property (p_trq_ovr)
        else $error("torque ovr off");

    // Full scale of 1000 so that code 500 gives exactly one full scale
    property p_iq_scale;
        ovr_a_q[`A_IQ_HI:`A_IQ_LO] == 10'h1F4 &&
            full_scale_current == 16'h03E8
            |=> torque_current_target_q == 16'sh03E8;
    endproperty
    a_iq_scale: assert property (p_iq_scale)
        else $error("iq scale wrong");

    // Must run during reset itself, so the default disable is lifted
    property p_reset_zero;
        disable iff (1'b0)
        rst |=> ovr_b_q == `RESET_WORD && recirc_enable_q;
    endproperty
    a_reset_zero: assert property (@(posedge clk) p_reset_zero)
        else $error("reset not zero");

    property p_sector;
        ovr_b_q[`B_SECT_HI:`B_SECT_LO] == `SECT_LAST_A &&
            $stable(last_sector)
            |=> recirc_sector_q == $past(last_sector);
    endproperty
    a_sector: assert property (p_sector)
        else $error("sector wrong");

    property p_recirc;
        s_wr_b ##1 1'b1
            |=> recirc_enable_q == !$past(pwdata[`B_RECIRC_N], 2);
    endproperty
    a_recirc: assert property (p_recirc)
        else $error("recirc polarity");

    property p_cur_off;
        ovr_b_q[`B_CUR_OFF] |=> !torque_regulator_en_q &&
            !velocity_regulator_en_q;
    endproperty
    a_cur_off: assert property (p_cur_off)
        else $error("regulators on");

    property p_vd_neg;
        ovr_b_q[`B_VD_HI:`B_VD_LO] == 10'h20C
            |=> direct_modulation_target_q < 0;
    endproperty
    a_vd_neg: assert property (p_vd_neg)
        else $error("vd sign wrong");

    property p_vq_src;
        ovr_b_q[`B_VQ_HI:`B_VQ_LO] == 10'h1F4
            |=> quadrature_modulation_target_q == 16'sh7FFF;
    endproperty
    a_vq_src: assert property (p_vq_src)
        else $error("vq scale wrong");

    // Pulse is one cycle wide and busy rises with it
    property p_start;
        s_wr_b and pwdata[`B_START] |=> param_measure_start_q &&
            measure_busy_q ##1 !param_measure_start_q;
    endproperty
    a_start: assert property (p_start)
        else $error("start lost");

    property p_commit;
        s_wr_b and pwdata[`B_COMMIT] |=> param_measure_commit_q;
    endproperty
    a_commit: assert property (p_commit)
        else $error("commit lost");

endmodule : override_bank
`default_nettype wire

// ===== src/override_defines.svh
// Purpose: Named offsets, field positions and constants of the override bank
// Assumes: APB byte addresses are four times the register index
// Notes: Definitions only
`ifndef OVERRIDE_DEFINES_SVH
`define OVERRIDE_DEFINES_SVH

// Register indexes and byte addresses
`define IDX_OVR_A 8'hEC
`define IDX_OVR_B 8'hEE
`define IDX_STATUS 8'hF8
`define ADDR_OVR_A {2'h0, `IDX_OVR_A, 2'h0}
`define ADDR_OVR_B {2'h0, `IDX_OVR_B, 2'h0}
`define ADDR_STATUS {2'h0, `IDX_STATUS, 2'h0}
`define RESET_WORD 32'h0000_0000

// Fields of control_override_a
`define A_SRC_SEL 10
`define A_IQ_HI 9
`define A_IQ_LO 0

// Fields of control_override_b
`define B_SECT_HI 30
`define B_SECT_LO 28
`define B_RECIRC_N 27
`define B_CUR_OFF 26
`define B_VD_HI 25
`define B_VD_LO 16
`define B_VQ_HI 15
`define B_VQ_LO 6
`define B_START 5
`define B_SEL_HI 4
`define B_SEL_LO 1
`define B_COMMIT 0

// Override code scaling
`define CODE_POS_MAX 11'sh1F4
`define CODE_NEG_MIN 11'sh200
`define CODE_WRAP 11'sh400
`define SCALE_DIV 28'sh00001F4
`define MOD_FULL_SCALE 16'h7FFF

// Sector codes that mean last active sector
`define SECT_LAST_A 3'h0
`define SECT_LAST_B 3'h7

`endif

// ===== src/override_pkg.sv
// Purpose: Shared types of the override bank
// Assumes: Constants live in override_defines.svh
// Notes: Nothing here is imported; use override_pkg::name
package override_pkg;

    typedef logic [9:0] code_t;
    typedef logic [15:0] scale_t;
    typedef logic signed [15:0] target_t;
    typedef logic [2:0] sector_t;

endpackage : override_pkg

// ===== src/override_scaler.sv
// Purpose: Turns a 10-bit signed override code into code/500 of a full scale
// Assumes: Code and full scale come from logic on the same clock
// Notes: Codes 501..511 are invalid; they yield zero and raise a flag
`timescale 1ns/100ps
`default_nettype none
`include "override_defines.svh"

module override_scaler (
    input wire logic clk,
    input wire logic rst,
    input wire override_pkg::code_t code,
    input wire override_pkg::scale_t full_scale,
    output override_pkg::target_t target_q,
    output logic invalid_q
);

    override_pkg::target_t target_d;
    logic invalid_d;

    // Signed numerator: code below or at the top, or code minus the wrap
    function automatic logic signed [10:0] numerator(
        input override_pkg::code_t c
    );
        logic signed [10:0] n;
        n = $signed({1'b0, c});
        if (n <= `CODE_POS_MAX) begin
            numerator = n;
        end else if (n >= `CODE_NEG_MIN) begin
            numerator = n - `CODE_WRAP;
        end else begin
            numerator = 11'sh000;
        end
    endfunction : numerator

    // Product then divide by the constant; a divider by 500 is cheap enough
    always_comb begin
        logic signed [27:0] prod;
        prod = 28'sh0000000;
        prod = 28'(numerator(code) * $signed({1'b0, full_scale}));
        target_d = 16'(prod / `SCALE_DIV);
        invalid_d = (numerator(code) == 11'sh000) && (code != 10'h000);
    end

    // Registered so the core sees a glitch-free target
    always_ff @(posedge clk) begin
        if (rst) begin
            target_q <= 16'sh0000;
            invalid_q <= 1'b0;
        end else begin
            target_q <= target_d;
            invalid_q <= invalid_d;
        end
    end

endmodule : override_scaler
`default_nettype wire

// ===== dv/override_bank_tb.sv
// Purpose: Self-checking bench of the debug override register bank
// Assumes: Zero-wait APB slave; decoded outputs settle within four cycles
// Notes: Target codes are picked so that code/500 divides exactly
`timescale 1ns/100ps
`default_nettype none
`include "override_defines.svh"

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
    err_total++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module override_bank_tb;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, er;
    logic [15:0] preset_lock_position = 16'h1111;
    logic [15:0] override_lock_position = 16'h2222;
    override_pkg::scale_t full_scale_current = 16'h03E8;
    logic velocity_regulator_off = 1'b0, param_measure_done = 1'b0;
    override_pkg::sector_t last_sector = 3'h5, recirc_sector_q;
    logic [15:0] lock_position_q;
    override_pkg::target_t torque_current_target_q, direct_modulation_target_q;
    override_pkg::target_t quadrature_modulation_target_q;
    logic torque_override_active_q, torque_regulator_en_q, recirc_enable_q;
    logic velocity_regulator_en_q, param_measure_start_q;
    logic param_measure_commit_q, measure_busy_q;
    logic [3:0] measure_select_q;
    int err_total = 0, samples_checked = 0;

    override_bank uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .preset_lock_position(preset_lock_position),
        .override_lock_position(override_lock_position),
        .full_scale_current(full_scale_current),
        .velocity_regulator_off(velocity_regulator_off),
        .last_sector(last_sector), .param_measure_done(param_measure_done),
        .lock_position_q(lock_position_q),
        .torque_current_target_q(torque_current_target_q),
        .torque_override_active_q(torque_override_active_q),
        .direct_modulation_target_q(direct_modulation_target_q),
        .quadrature_modulation_target_q(quadrature_modulation_target_q),
        .torque_regulator_en_q(torque_regulator_en_q),
        .velocity_regulator_en_q(velocity_regulator_en_q),
        .recirc_sector_q(recirc_sector_q), .recirc_enable_q(recirc_enable_q),
        .measure_select_q(measure_select_q),
        .param_measure_start_q(param_measure_start_q),
        .param_measure_commit_q(param_measure_commit_q),
        .measure_busy_q(measure_busy_q));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    // One APB transfer; request held until pready is seen high at an edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            $display("[ERR] %0t no pready", $time);
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // Let decode and scaler stages land before looking
    task settle;
        repeat (4) @(posedge clk);
        #1;
    endtask : settle

    task wr_a(input logic [31:0] d);
        apb(1'b1, `ADDR_OVR_A, d);
        settle();
    endtask : wr_a

    // Fields: sector, recirc_n, cur_off, vd, vq, start, select, commit
    task wr_b(input logic [2:0] s, input logic rn, input logic co,
              input logic [9:0] vd, input logic [9:0] vq, input logic st,
              input logic [3:0] se, input logic cm);
        apb(1'b1, `ADDR_OVR_B, {1'b0, s, rn, co, vd, vq, st, se, cm});
    endtask : wr_b

    task t_reset;
        settle();
        `CHK(torque_current_target_q, 16'h0000)
        `CHK(direct_modulation_target_q, 16'h0000)
        `CHK(torque_regulator_en_q, 1'b1)
        `CHK(recirc_enable_q, 1'b1)
        `CHK(recirc_sector_q, last_sector)
        `CHK(param_measure_start_q, 1'b0)
        apb(1'b0, `ADDR_OVR_B, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        `CHK(er, 1'b0)
        apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
        `CHK(rd[3:0], 4'hC)
        $display("test reset done");
    endtask : t_reset

    task t_lock;
        wr_a(32'h0000_0000);
        `CHK(lock_position_q, 16'h1111)
        wr_a(32'h0000_0400);
        `CHK(lock_position_q, 16'h2222)
        $display("test lock done");
    endtask : t_lock

    // Boundary codes on both sides of the signed wrap
    task t_torque;
        logic [9:0] c[5];
        logic [15:0] e[5];
        c = '{10'h0FA, 10'h1F4, 10'h306, 10'h20C, 10'h000};
        e = '{16'h01F4, 16'h03E8, 16'hFE0C, 16'hFC18, 16'h0000};
        @(posedge clk) velocity_regulator_off <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr_a({22'h000000, c[i]});
            `CHK(torque_current_target_q, e[i])
            `CHK(torque_override_active_q, 1'b1)
        end
        $display("test torque done");
    endtask : t_torque

    // Last sector moved off code 5 so a pass-through cannot hide
    task t_sector;
        logic [2:0] s, es;
        @(posedge clk) last_sector <= 3'h2;
        for (int i = 0; i < 8; i++) begin
            s = i[2:0];
            wr_b(s, s[0], 1'b0, 10'h000, 10'h000, 1'b0, 4'h0, 1'b0);
            settle();
            es = (s == 3'h0 || s == 3'h7) ? last_sector : s;
            `CHK(recirc_sector_q, es)
            `CHK(recirc_enable_q, ~s[0])
        end
        $display("test sector done");
    endtask : t_sector

    task t_volt;
        wr_b(3'h0, 1'b0, 1'b1, 10'h1F4, 10'h20C, 1'b0, 4'h0, 1'b0);
        settle();
        `CHK(direct_modulation_target_q, 16'h7FFF)
        `CHK(quadrature_modulation_target_q, 16'h8001)
        `CHK(torque_regulator_en_q, 1'b0)
        `CHK(velocity_regulator_en_q, 1'b0)
        `CHK(torque_override_active_q, 1'b0)
        wr_b(3'h0, 1'b0, 1'b0, 10'h20C, 10'h1F4, 1'b0, 4'h0, 1'b0);
        settle();
        `CHK(direct_modulation_target_q, 16'h8001)
        `CHK(quadrature_modulation_target_q, 16'h7FFF)
        `CHK(torque_regulator_en_q, 1'b1)
        @(posedge clk) velocity_regulator_off <= 1'b0;
        $display("test voltage done");
    endtask : t_volt

    // Start and commit must each give exactly one pulse
    task t_measure;
        int ns, nc;
        ns = 0;
        nc = 0;
        // The pulse stands in the cycle right after the write edge
        wr_b(3'h0, 1'b0, 1'b0, 10'h000, 10'h000, 1'b1, 4'hA, 1'b0);
        #1;
        repeat (5) begin
            if (param_measure_start_q === 1'b1) ns++;
            @(posedge clk);
            #1;
        end
        `CHK(ns, 1)
        `CHK(measure_select_q, 4'hA)
        `CHK(measure_busy_q, 1'b1)
        @(posedge clk) param_measure_done <= 1'b1;
        @(posedge clk) param_measure_done <= 1'b0;
        settle();
        `CHK(measure_busy_q, 1'b0)
        wr_b(3'h0, 1'b0, 1'b0, 10'h000, 10'h000, 1'b0, 4'h0, 1'b1);
        #1;
        repeat (5) begin
            if (param_measure_commit_q === 1'b1) nc++;
            @(posedge clk);
            #1;
        end
        `CHK(nc, 1)
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        `CHK(er, 1'b1)
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        $display("test measure done");
    endtask : t_measure

    // Mid-run reset must drop every override back to zero
    task t_rerun;
        wr_b(3'h2, 1'b1, 1'b1, 10'h1F4, 10'h1F4, 1'b0, 4'h3, 1'b0);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        $display("test rerun done");
    endtask : t_rerun

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_lock();
        t_torque();
        t_sector();
        t_volt();
        t_measure();
        t_rerun();
        stop_test();
    end
endmodule : override_bank_tb
`default_nettype wire
